// File: dlr_line_ctrl.sv
// Dialer hook, hold-line and hands-free line control top level
//
// Notes on behaviour
// R1: Mute pin is open drain, pulled low only by software setting.
// R2: Line-break pin is open drain, set only by software.
// R3: Line make output high means line made, low means broken.
// R4: Hook pin rising edge gives on-hook status and dialer interrupt.
// R5: Hook pin falling edge gives off-hook, clears hold and hands-free, interrupts.
// R6: Hold request low pulse clears hands-free, toggles hold, interrupts.
// R7: Hold request acts only while line make output is high.
// R8: Hands-free request high pulse clears hold, toggles hands-free, interrupts.
// R9: Hold state high forces the line made.
// R10: Hands-free state high forces the line made.
// R11: Line make output held low while automatic enable bit is clear.
// R12: On-hook with hold: hold request edge raises no interrupt.
// R13: Function runs in normal, green, sleep modes; suspended in idle.
// R14: Automatic line make low only on-hook with hold and hands-free clear.
// R15: Pins synchronised; each edge acted on at most once.
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dlr_line_ctrl
  import dlr_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic hook_switch_in_i,
  input wire logic hold_request_in_i,
  input wire logic handsfree_request_in_i,
  input wire logic [7:0] bus_addr_i,
  input wire logic [7:0] bus_wdata_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  output logic [7:0] bus_rdata_o,
  output logic hold_line_state_o,
  output logic handsfree_state_o,
  output logic line_make_out_o,
  output logic line_break_out_o,
  output logic line_break_out_oe_o,
  output logic mute_out_o,
  output logic mute_out_oe_o,
  output logic dialer_irq_o,
  output logic [7:0] dialer_irq_vector_o
);

  // ==========================================================================
  // Pin synchronisers
  logic hook_lvl;
  logic hook_rise;
  logic hook_fall;
  logic hold_lvl;
  logic hold_fall;
  logic hf_lvl;
  logic hf_rise;

  dlr_sync_edge #(.RST_LEVEL(DLR_RST_HOOK_LVL)) u_hook_sync ( // [R15]
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .pin_i(hook_switch_in_i),
    .level_o(hook_lvl),
    .rise_o(hook_rise),
    .fall_o(hook_fall)
  );

  dlr_sync_edge #(.RST_LEVEL(DLR_RST_HOLD_LVL)) u_hold_sync ( // [R15]
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .pin_i(hold_request_in_i),
    .level_o(hold_lvl),
    .rise_o(),
    .fall_o(hold_fall)
  );

  dlr_sync_edge #(.RST_LEVEL(DLR_RST_HF_LVL)) u_hf_sync ( // [R15]
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .pin_i(handsfree_request_in_i),
    .level_o(hf_lvl),
    .rise_o(hf_rise),
    .fall_o()
  );

  // ==========================================================================
  // Register port
  logic auto_en;
  logic break_float;
  logic mute_float;
  dlr_mode_t mode;
  logic [4:0] status;

  assign status = {hook_lvl, hold_line_state_o, hold_lvl, handsfree_state_o, hf_lvl};

  dlr_regs u_regs (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .bus_addr_i(bus_addr_i),
    .bus_wdata_i(bus_wdata_i),
    .bus_wr_i(bus_wr_i),
    .bus_rd_i(bus_rd_i),
    .status_i(status),
    .bus_rdata_o(bus_rdata_o),
    .auto_en_o(auto_en),
    .break_float_o(break_float),
    .mute_float_o(mute_float),
    .mode_o(mode)
  );

  // ==========================================================================
  // Dialer state
  dlr_hook_t hook_st;
  logic hold_st;
  logic hf_st;
  logic irq;
  logic make;
  logic brk_oe;
  logic mute_oe;
  dlr_hook_t next_hook_st;
  logic next_hold_st;
  logic next_hf_st;
  logic next_irq;
  logic next_make;
  logic next_brk_oe;
  logic next_mute_oe;
  logic active;

  assign active = (mode != DLR_MODE_IDLE); // [R13]

  always_comb begin
    next_hook_st = hook_st;
    next_hold_st = hold_st;
    next_hf_st = hf_st;
    next_irq = 1'b0;
    if (active) begin // [R13]
      if (hold_fall && make) begin // [R7]
        next_hf_st = 1'b0; // [R6]
        next_hold_st = !hold_st;
        if (!(hook_st == DLR_ON_HOOK && hold_st)) begin // [R12]
          next_irq = 1'b1;
        end
      end
      if (hf_rise) begin // [R8]
        next_hold_st = 1'b0;
        next_hf_st = !next_hf_st;
        next_irq = 1'b1;
      end
      if (hook_rise) begin // [R4]
        next_hook_st = DLR_ON_HOOK;
        next_irq = 1'b1;
      end
      if (hook_fall) begin // [R5]
        next_hook_st = DLR_OFF_HOOK;
        next_hold_st = 1'b0;
        next_hf_st = 1'b0;
        next_irq = 1'b1;
      end
    end
    // Line made while auto_en is set, unless on-hook with both states clear
    case (next_hook_st)
      DLR_ON_HOOK: next_make = auto_en && (next_hold_st || next_hf_st); // [R9] [R10] [R11] [R14]
      DLR_OFF_HOOK: next_make = auto_en; // [R3] [R11] [R14]
      default: next_make = 1'b0;
    endcase
    next_brk_oe = !break_float; // [R2]
    next_mute_oe = !mute_float; // [R1]
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      hook_st <= DLR_RST_HOOK;
      hold_st <= 1'b0;
      hf_st <= 1'b0;
      irq <= 1'b0;
      make <= 1'b0;
      brk_oe <= 1'b0;
      mute_oe <= 1'b0;
    end else begin
      hook_st <= next_hook_st;
      hold_st <= next_hold_st;
      hf_st <= next_hf_st;
      irq <= next_irq;
      make <= next_make;
      brk_oe <= next_brk_oe;
      mute_oe <= next_mute_oe;
    end
  end

  // ==========================================================================
  // Outputs
  assign hold_line_state_o = hold_st;
  assign handsfree_state_o = hf_st;
  assign line_make_out_o = make;
  assign line_break_out_o = 1'b0;
  assign line_break_out_oe_o = brk_oe;
  assign mute_out_o = 1'b0;
  assign mute_out_oe_o = mute_oe;
  assign dialer_irq_o = irq;
  assign dialer_irq_vector_o = DLR_IRQ_VECTOR;

  // ==========================================================================
  // Checks
  chk_mute_sw_drive: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R1]
    bus_wr_i && bus_addr_i == DLR_ADDR_DIAL |-> ##2 (mute_out_oe_o == !$past(bus_wdata_i[DLR_BIT_MUTE], 2)))
    else $error("mute drive does not follow software");

  chk_break_sw_only: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R2]
    !bus_wr_i [*2] |=> $stable(line_break_out_oe_o))
    else $error("line break changed without a write");

  chk_make_level: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R3]
    line_make_out_o |-> $past(auto_en) && (hook_st == DLR_OFF_HOOK || hold_st || hf_st))
    else $error("line made without cause");

  chk_onhook_rise: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R4]
    hook_rise && active |=> hook_st == DLR_ON_HOOK && dialer_irq_o)
    else $error("hook rise not handled");

  chk_offhook_fall: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R5]
    hook_fall && active |=> hook_st == DLR_OFF_HOOK && !hold_line_state_o && !handsfree_state_o && dialer_irq_o)
    else $error("hook fall not handled");

  chk_hold_toggle: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R6]
    hold_fall && active && make && !hf_rise && !hook_rise && !hook_fall
    |=> hold_line_state_o != $past(hold_line_state_o) && !handsfree_state_o)
    else $error("hold request not handled");

  chk_hold_ignored: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R7]
    hold_fall && !make && !hf_rise && !hook_fall |=> $stable(hold_line_state_o))
    else $error("hold request acted on while line broken");

  chk_hf_toggle: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R8]
    hf_rise && active && !hold_fall && !hook_fall
    |=> handsfree_state_o != $past(handsfree_state_o) && !hold_line_state_o && dialer_irq_o)
    else $error("hands-free request not handled");

  chk_hold_makes: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R9]
    hold_line_state_o && auto_en && $stable(auto_en) |=> line_make_out_o || !hold_line_state_o)
    else $error("hold state does not make the line");

  chk_hf_makes: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R10]
    handsfree_state_o && auto_en && $stable(auto_en) |=> line_make_out_o || !handsfree_state_o)
    else $error("hands-free state does not make the line");

  chk_auto_off: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R11]
    !auto_en |=> !line_make_out_o)
    else $error("line made with automatic control off");

  chk_hold_noirq: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R12]
    hold_fall && hook_st == DLR_ON_HOOK && hold_st && !hf_rise && !hook_rise && !hook_fall |=> !dialer_irq_o)
    else $error("interrupt raised on-hook with hold");

  chk_idle_freeze: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R13]
    !active |=> $stable(hold_line_state_o) && $stable(handsfree_state_o) && !dialer_irq_o)
    else $error("dialer state changed in idle");

  chk_break_when_idle_hook: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R14]
    auto_en && hook_st == DLR_ON_HOOK && !hold_st && !hf_st && $stable(auto_en) && $stable(hook_st)
    |-> !line_make_out_o)
    else $error("line made on-hook with no hold or hands-free");

  chk_edge_once: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R15]
    hook_rise |=> !hook_rise && !hook_fall)
    else $error("hook edge reported twice");

  chk_irq_vector: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R4]
    dialer_irq_o |-> dialer_irq_vector_o == DLR_IRQ_VECTOR)
    else $error("dialer interrupt vector wrong");

  chk_mute_data_low: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R1]
    mute_out_oe_o |-> !mute_out_o)
    else $error("mute pin driven high");

  chk_break_data_low: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R2]
    line_break_out_oe_o |-> !line_break_out_o)
    else $error("line break pin driven high");

  chk_break_follows_sw: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R2]
    bus_wr_i && bus_addr_i == DLR_ADDR_DIAL |-> ##2 (line_break_out_oe_o == !$past(bus_wdata_i[DLR_BIT_BREAK], 2)))
    else $error("line break drive does not follow software");

  chk_irq_has_cause: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R15]
    !(hook_rise || hook_fall || hf_rise || hold_fall) |=> !dialer_irq_o)
    else $error("interrupt raised without a pin event");

  chk_auto_make_table: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R14]
    auto_en |=> line_make_out_o == (hook_st == DLR_OFF_HOOK || hold_st || hf_st))
    else $error("line make does not match hook, hold and hands-free");

  chk_hold_clears_hf: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R6]
    hold_fall && active && make && !hf_rise |=> !handsfree_state_o)
    else $error("hold request left hands-free set");

  chk_hold_irq: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R6]
    hold_fall && active && make && !(hook_st == DLR_ON_HOOK && hold_st) |=> dialer_irq_o)
    else $error("hold request raised no interrupt");

  chk_states_quiet: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R15]
    !(hook_fall || hf_rise || hold_fall) |=> $stable(hold_line_state_o) && $stable(handsfree_state_o))
    else $error("state changed without a pin event");

  chk_hook_quiet: assert property (@(posedge clock_i) disable iff (!rst_n_i) // [R15]
    !hook_rise && !hook_fall |=> $stable(hook_st))
    else $error("hook status changed without a hook edge");

endmodule // dlr_line_ctrl
`default_nettype wire

// File: dlr_pkg.sv
// Shared constants and types for the dialer hook, hold and hands-free block
package dlr_pkg;

  // ==========================================================================
  // Register map
  localparam logic [7:0] DLR_ADDR_DIAL = 8'h16;
  localparam logic [7:0] DLR_ADDR_MODE = 8'h17;

  // ==========================================================================
  // Dialer register field positions
  localparam int DLR_BIT_HF_PIN = 0;
  localparam int DLR_BIT_HF_ST = 1;
  localparam int DLR_BIT_HOLD_PIN = 2;
  localparam int DLR_BIT_HOLD_ST = 3;
  localparam int DLR_BIT_HOOK_PIN = 4;
  localparam int DLR_BIT_AUTO = 5;
  localparam int DLR_BIT_BREAK = 6;
  localparam int DLR_BIT_MUTE = 7;

  // ==========================================================================
  // Values after reset and the fixed interrupt vector
  localparam logic DLR_RST_AUTO = 1'b0;
  localparam logic DLR_RST_BREAK_FLOAT = 1'b1;
  localparam logic DLR_RST_MUTE_FLOAT = 1'b1;
  localparam logic DLR_RST_HOOK_LVL = 1'b1;
  localparam logic DLR_RST_HOLD_LVL = 1'b1;
  localparam logic DLR_RST_HF_LVL = 1'b0;
  localparam logic [7:0] DLR_IRQ_VECTOR = 8'h18;

  // ==========================================================================
  // Operating modes and hook status
  typedef enum logic [3:0] {
    DLR_MODE_NORMAL = 4'h1,
    DLR_MODE_GREEN = 4'h2,
    DLR_MODE_SLEEP = 4'h4,
    DLR_MODE_IDLE = 4'h8
  } dlr_mode_t;

  typedef enum logic [1:0] {
    DLR_ON_HOOK = 2'h1,
    DLR_OFF_HOOK = 2'h2
  } dlr_hook_t;

  localparam dlr_mode_t DLR_RST_MODE = DLR_MODE_NORMAL;
  localparam dlr_hook_t DLR_RST_HOOK = DLR_ON_HOOK;

  // Accept only the four one-hot mode codes
  function automatic logic dlr_mode_ok(input logic [3:0] code);
    dlr_mode_ok = (code == DLR_MODE_NORMAL) || (code == DLR_MODE_GREEN) ||
                  (code == DLR_MODE_SLEEP) || (code == DLR_MODE_IDLE);
  endfunction

endpackage

// File: dlr_sync_edge.sv
// Two-stage pin synchroniser with edge detection
`timescale 1ns/1ps
`default_nettype none
module dlr_sync_edge
  import dlr_pkg::*;
#(
  parameter logic RST_LEVEL = 1'b0
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic pin_i,
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  // ==========================================================================
  // Synchroniser and edge history
  logic meta;
  logic sync;
  logic prev;
  logic next_meta;
  logic next_sync;
  logic next_prev;

  always_comb begin
    next_meta = pin_i;
    next_sync = meta;
    next_prev = sync;
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      meta <= RST_LEVEL;
      sync <= RST_LEVEL;
      prev <= RST_LEVEL;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  // One pulse per transition
  assign level_o = sync;
  assign rise_o = sync && !prev;
  assign fall_o = !sync && prev;

endmodule // dlr_sync_edge
`default_nettype wire

// File: dlr_regs.sv
// Register port slave: dialer control bits and operating mode
`timescale 1ns/1ps
`default_nettype none
module dlr_regs
  import dlr_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [7:0] bus_addr_i,
  input wire logic [7:0] bus_wdata_i,
  input wire logic bus_wr_i,
  input wire logic bus_rd_i,
  input wire logic [4:0] status_i,
  output logic [7:0] bus_rdata_o,
  output logic auto_en_o,
  output logic break_float_o,
  output logic mute_float_o,
  output dlr_mode_t mode_o
);

  // ==========================================================================
  // Control registers
  logic auto_en;
  logic break_float;
  logic mute_float;
  dlr_mode_t mode;
  logic [7:0] rdata;
  logic next_auto_en;
  logic next_break_float;
  logic next_mute_float;
  dlr_mode_t next_mode;
  logic [7:0] next_rdata;

  always_comb begin
    next_auto_en = auto_en;
    next_break_float = break_float;
    next_mute_float = mute_float;
    next_mode = mode;
    next_rdata = 8'h00;
    if (bus_wr_i && bus_addr_i == DLR_ADDR_DIAL) begin
      next_auto_en = bus_wdata_i[DLR_BIT_AUTO];
      next_break_float = bus_wdata_i[DLR_BIT_BREAK];
      next_mute_float = bus_wdata_i[DLR_BIT_MUTE];
    end
    if (bus_wr_i && bus_addr_i == DLR_ADDR_MODE && dlr_mode_ok(bus_wdata_i[3:0])) begin
      next_mode = dlr_mode_t'(bus_wdata_i[3:0]);
    end
    if (bus_rd_i) begin
      case (bus_addr_i)
        DLR_ADDR_DIAL: next_rdata = {mute_float, break_float, auto_en, status_i};
        DLR_ADDR_MODE: next_rdata = {4'h0, mode};
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      auto_en <= DLR_RST_AUTO;
      break_float <= DLR_RST_BREAK_FLOAT;
      mute_float <= DLR_RST_MUTE_FLOAT;
      mode <= DLR_RST_MODE;
      rdata <= 8'h00;
    end else begin
      auto_en <= next_auto_en;
      break_float <= next_break_float;
      mute_float <= next_mute_float;
      mode <= next_mode;
      rdata <= next_rdata;
    end
  end

  assign bus_rdata_o = rdata;
  assign auto_en_o = auto_en;
  assign break_float_o = break_float;
  assign mute_float_o = mute_float;
  assign mode_o = mode;

endmodule // dlr_regs
`default_nettype wire

// File: dlr_phone_model.sv
// Behavioural telephone line side: hook switch, buttons and pulled-up line pins
`timescale 1ns/1ps
`default_nettype none
module dlr_phone_model (
  input wire logic clock_i,
  input wire logic mute_out_i,
  input wire logic mute_out_oe_i,
  input wire logic line_break_out_i,
  input wire logic line_break_out_oe_i,
  output logic hook_switch_o,
  output logic hold_request_o,
  output logic handsfree_request_o,
  output logic mute_line_o,
  output logic line_break_line_o
);
  // ==========================================================================
  // Open-drain lines with pull-ups
  assign mute_line_o = mute_out_oe_i ? mute_out_i : 1'b1;
  assign line_break_line_o = line_break_out_oe_i ? line_break_out_i : 1'b1;

  // ==========================================================================
  // Idle levels: on-hook, buttons released
  initial begin
    hook_switch_o = 1'b1;
    hold_request_o = 1'b1;
    handsfree_request_o = 1'b0;
  end

  // Hold button: low pulse, each level kept four clocks
  task automatic press_hold();
    @(posedge clock_i);
    hold_request_o <= 1'b0;
    repeat (4) @(posedge clock_i);
    hold_request_o <= 1'b1;
    repeat (4) @(posedge clock_i);
  endtask

  // Hands-free button: high pulse
  task automatic press_hf();
    @(posedge clock_i);
    handsfree_request_o <= 1'b1;
    repeat (4) @(posedge clock_i);
    handsfree_request_o <= 1'b0;
    repeat (4) @(posedge clock_i);
  endtask

  // Hook switch: new level, then settle
  task automatic set_hook(input logic lvl);
    @(posedge clock_i);
    hook_switch_o <= lvl;
    repeat (8) @(posedge clock_i);
  endtask
endmodule // dlr_phone_model
`default_nettype wire

// File: tb_telephone_dialer_line_control.sv
// Self-checking testbench for the dialer line control block
`timescale 1ns/1ps
`default_nettype none
module tb_telephone_dialer_line_control
  import dlr_pkg::*;
;
  // ==========================================================================
  // Clock, reset and wiring
  logic clock_i = 1'b0;
  logic rst_n_i;
  logic [7:0] bus_addr_i;
  logic [7:0] bus_wdata_i;
  logic bus_wr_i;
  logic bus_rd_i;
  logic [7:0] bus_rdata_o;
  logic hook_w, hold_w, hf_w, hold_st, hf_st, make_w, brk_w, brk_oe, mute_w, mute_oe, irq_w;
  logic mute_line, brk_line;
  logic [7:0] vec_w;
  logic [7:0] irq_cnt = 8'h00;
  logic [7:0] irq_mark = 8'h00;
  logic [7:0] vec_bad = 8'h00;
  logic [7:0] d;
  int fails = 0;
  int tests_run = 0;

  always #5 clock_i = ~clock_i;

  dlr_line_ctrl i_dlr_line_ctrl (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .hook_switch_in_i(hook_w), .hold_request_in_i(hold_w),
    .handsfree_request_in_i(hf_w), .bus_addr_i(bus_addr_i), .bus_wdata_i(bus_wdata_i),
    .bus_wr_i(bus_wr_i), .bus_rd_i(bus_rd_i), .bus_rdata_o(bus_rdata_o),
    .hold_line_state_o(hold_st), .handsfree_state_o(hf_st), .line_make_out_o(make_w),
    .line_break_out_o(brk_w), .line_break_out_oe_o(brk_oe), .mute_out_o(mute_w),
    .mute_out_oe_o(mute_oe), .dialer_irq_o(irq_w), .dialer_irq_vector_o(vec_w));

  dlr_phone_model i_dlr_phone_model (
    .clock_i(clock_i), .mute_out_i(mute_w), .mute_out_oe_i(mute_oe), .line_break_out_i(brk_w),
    .line_break_out_oe_i(brk_oe), .hook_switch_o(hook_w), .hold_request_o(hold_w),
    .handsfree_request_o(hf_w), .mute_line_o(mute_line), .line_break_line_o(brk_line));

  // ==========================================================================
  // Interrupt pulse counter and vector watch
  always @(posedge clock_i) begin
    if (irq_w === 1'b1) begin
      irq_cnt <= irq_cnt + 8'h01;
      if (vec_w !== 8'h18) vec_bad <= vec_bad + 8'h01;
    end
  end

  // ==========================================================================
  // Helpers
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    tests_run++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_i);
    bus_addr_i <= a;
    bus_wdata_i <= v;
    bus_wr_i <= 1'b1;
    @(posedge clock_i);
    bus_wr_i <= 1'b0;
    repeat (2) @(posedge clock_i);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge clock_i);
    bus_addr_i <= a;
    bus_rd_i <= 1'b1;
    @(posedge clock_i);
    bus_rd_i <= 1'b0;
    #1 v = bus_rdata_o;
  endtask

  // Compare hold, hands-free, line make and new interrupt pulses
  task automatic look(input logic h, input logic f, input logic m, input logic [7:0] n);
    #1;
    chk("hold_line_state", {7'h00, h}, {7'h00, hold_st});
    chk("handsfree_state", {7'h00, f}, {7'h00, hf_st});
    chk("line_make_out", {7'h00, m}, {7'h00, make_w});
    chk("irq_pulses", n, irq_cnt - irq_mark);
    irq_mark = irq_cnt;
  endtask

  task automatic end_sim();
    if (fails == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset_and_map();
    rd(DLR_ADDR_DIAL, d);
    chk("dial_reg", 8'hd4, d);
    rd(DLR_ADDR_MODE, d);
    chk("mode_reg", 8'h01, d);
    rd(8'h33, d);
    chk("unmapped", 8'h00, d);
    look(1'b0, 1'b0, 1'b0, 8'h00);
  endtask

  task automatic t_soft_pins();
    wr(DLR_ADDR_DIAL, 8'h00);
    chk("mute_line", 8'h00, {7'h00, mute_line});
    chk("break_line", 8'h00, {7'h00, brk_line});
    i_dlr_phone_model.press_hf();
    look(1'b0, 1'b1, 1'b0, 8'h01);
    chk("break_line_pins", 8'h00, {7'h00, brk_line});
    wr(DLR_ADDR_DIAL, 8'he0);
    look(1'b0, 1'b1, 1'b1, 8'h00);
    chk("mute_float", 8'h01, {7'h00, mute_line});
  endtask

  task automatic t_hook_hold_hf();
    i_dlr_phone_model.press_hf();
    look(1'b0, 1'b0, 1'b0, 8'h01);
    i_dlr_phone_model.press_hold();
    look(1'b0, 1'b0, 1'b0, 8'h00);
    i_dlr_phone_model.set_hook(1'b0);
    look(1'b0, 1'b0, 1'b1, 8'h01);
    i_dlr_phone_model.press_hold();
    look(1'b1, 1'b0, 1'b1, 8'h01);
    rd(DLR_ADDR_DIAL, d);
    chk("dial_status", 8'hec, d);
    i_dlr_phone_model.press_hf();
    look(1'b0, 1'b1, 1'b1, 8'h01);
    i_dlr_phone_model.set_hook(1'b1);
    look(1'b0, 1'b1, 1'b1, 8'h01);
    i_dlr_phone_model.press_hold();
    look(1'b1, 1'b0, 1'b1, 8'h01);
    i_dlr_phone_model.press_hold();
    look(1'b0, 1'b0, 1'b0, 8'h00);
    i_dlr_phone_model.set_hook(1'b0);
    i_dlr_phone_model.press_hf();
    i_dlr_phone_model.set_hook(1'b1);
    look(1'b0, 1'b1, 1'b1, 8'h03);
    i_dlr_phone_model.set_hook(1'b0);
    look(1'b0, 1'b0, 1'b1, 8'h01);
    i_dlr_phone_model.set_hook(1'b1);
    look(1'b0, 1'b0, 1'b0, 8'h01);
  endtask

  task automatic t_modes();
    wr(DLR_ADDR_MODE, 8'h08);
    i_dlr_phone_model.press_hf();
    look(1'b0, 1'b0, 1'b0, 8'h00);
    wr(DLR_ADDR_MODE, 8'h03);
    rd(DLR_ADDR_MODE, d);
    chk("mode_bad_code", 8'h08, d);
    wr(DLR_ADDR_MODE, 8'h02);
    i_dlr_phone_model.press_hf();
    look(1'b0, 1'b1, 1'b1, 8'h01);
    wr(DLR_ADDR_MODE, 8'h04);
    i_dlr_phone_model.press_hf();
    look(1'b0, 1'b0, 1'b0, 8'h01);
    wr(DLR_ADDR_MODE, 8'h01);
    i_dlr_phone_model.press_hf();
    look(1'b0, 1'b1, 1'b1, 8'h01);
    wr(DLR_ADDR_DIAL, 8'hc0);
    look(1'b0, 1'b1, 1'b0, 8'h00);
    chk("irq_vector", 8'h00, vec_bad);
  endtask

  // ==========================================================================
  // Main sequence and watchdog
  initial begin
    rst_n_i <= 1'b0;
    bus_addr_i <= 8'h00;
    bus_wdata_i <= 8'h00;
    bus_wr_i <= 1'b0;
    bus_rd_i <= 1'b0;
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_reset_and_map();
    t_soft_pins();
    t_hook_hold_hf();
    t_modes();
    end_sim();
  end

  initial begin
    #100us;
    fails++;
    end_sim();
  end
endmodule // tb_telephone_dialer_line_control
`default_nettype wire
